//--- ccr_readout.sv
// charge counter readout: two 16-bit counters behind an AHB-Lite slave
// Functional notes
// - buck2 sleep counter, read-only, resets zero
// - linear counter counts linear pulses only in standalone mode
// - each counter split into high, low bytes
// - reading a counter register holds its updates; linear counter not held during calibration
// - pulses arriving during hold are lost
// - high-byte read snapshots low byte into shadow
// - low-byte read returns shadow value
// - calibration: linear counter counts 10MHz cycles
// - calibration result stays until counter clear
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"
module ccr_readout (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic buck2_pulse,
   input wire logic sleep_mode_active,
   input wire logic linear_pulse,
   input wire logic standalone_linear_regulator,
   input wire logic cal_active,
   input wire logic cal_tick_10mhz,
   input wire logic counter_clear_event
);
   ////////////////////////////////////////////////////////////////////////////
   // address phase capture
   ccr_pkg::ccr_req_t req_reg;
   ccr_pkg::ccr_req_t req_next;
   ccr_pkg::ccr_phase_t phase_reg;
   ccr_pkg::ccr_phase_t phase_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   wire logic take = hsel && hready &&
                     (htrans == `CCR_HTRANS_NONSEQ || htrans == `CCR_HTRANS_SEQ);
   wire logic word_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h000000);
   assign req_next.index = word_ok ? haddr[9:2] : 8'hff;
   assign req_next.valid = take;
   assign req_next.write = hwrite;
   assign phase_next = !take ? ccr_pkg::CCR_IDLE :
                       (hwrite ? ccr_pkg::CCR_WRITE : ccr_pkg::CCR_READ);
   ////////////////////////////////////////////////////////////////////////////
   // hold and snapshot decode; hold spans address and data phase only
   wire logic rd_now = take && !hwrite && word_ok;
   // misaligned or far reads still answer, with zero, so stale data never shows
   wire logic rd_any = take && !hwrite;
   wire logic rd_data = (phase_reg == ccr_pkg::CCR_READ);
   wire logic addr_b2 = rd_now && (haddr[9:2] == `CCR_IDX_B2_HIGH ||
                                   haddr[9:2] == `CCR_IDX_B2_LOW);
   wire logic addr_lin = rd_now && (haddr[9:2] == `CCR_IDX_LIN_HIGH ||
                                    haddr[9:2] == `CCR_IDX_LIN_LOW);
   wire logic data_b2 = rd_data && (req_reg.index == `CCR_IDX_B2_HIGH ||
                                    req_reg.index == `CCR_IDX_B2_LOW);
   wire logic data_lin = rd_data && (req_reg.index == `CCR_IDX_LIN_HIGH ||
                                     req_reg.index == `CCR_IDX_LIN_LOW);
   wire logic hold_b2 = addr_b2 || data_b2;
   wire logic hold_lin = addr_lin || data_lin;
   wire logic snap_b2 = rd_now && (haddr[9:2] == `CCR_IDX_B2_HIGH);
   wire logic snap_lin = rd_now && (haddr[9:2] == `CCR_IDX_LIN_HIGH);
   ////////////////////////////////////////////////////////////////////////////
   // calibration: clear at start, then count ticks; result kept until clear
   logic cal_d_reg;
   logic cal_done_reg;
   wire logic cal_start = cal_active && !cal_d_reg;
   // the fall cycle counts as done, else one stray pulse lands on the result
   wire logic lin_count_src = cal_active ? cal_tick_10mhz :
                              ((cal_done_reg || cal_d_reg) ? 1'b0 :
                               (linear_pulse && standalone_linear_regulator));
   ccr_pkg::ccr_cnt_ctl_t ctl_b2;
   ccr_pkg::ccr_cnt_ctl_t ctl_lin;
   assign ctl_b2.pulse = buck2_pulse && sleep_mode_active;
   assign ctl_b2.clear = counter_clear_event;
   assign ctl_b2.hold = hold_b2;
   assign ctl_lin.pulse = lin_count_src;
   assign ctl_lin.clear = counter_clear_event;
   // calibration result would be corrupted by a hold, so ticks are never held
   assign ctl_lin.hold = hold_lin && !cal_active;
   logic [15:0] b2_count;
   logic [7:0] b2_shadow;
   logic [15:0] lin_count;
   logic [7:0] lin_shadow;
   ccr_counter #(
      .WIDTH(16)
   ) u_b2 (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctl(ctl_b2),
      .load(1'b0),
      .load_value(16'h0000),
      .snap_low(snap_b2),
      .count(b2_count),
      .shadow_low(b2_shadow)
   );
   ccr_counter #(
      .WIDTH(16)
   ) u_lin (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctl(ctl_lin),
      .load(cal_start),
      .load_value(16'h0000),
      .snap_low(snap_lin),
      .count(lin_count),
      .shadow_low(lin_shadow)
   );
   ////////////////////////////////////////////////////////////////////////////
   // read mux, registered one cycle after address phase
   wire logic [7:0] status_byte = {5'b00000, hold_lin, hold_b2, cal_active};
   wire logic [7:0] rd_byte =
      (req_next.index == `CCR_IDX_B2_HIGH) ? b2_count[15:8] :
      (req_next.index == `CCR_IDX_B2_LOW) ? b2_shadow :
      (req_next.index == `CCR_IDX_LIN_HIGH) ? lin_count[15:8] :
      (req_next.index == `CCR_IDX_LIN_LOW) ? lin_shadow :
      (req_next.index == `CCR_IDX_STATUS) ? status_byte :
      8'h00;
   assign hrdata_next = rd_any ? {24'h000000, rd_byte} : hrdata_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_reg <= '0;
         phase_reg <= ccr_pkg::CCR_IDLE;
         hrdata_reg <= 32'h00000000;
         cal_d_reg <= 1'b0;
         cal_done_reg <= 1'b0;
      end else begin
         if (hready) begin
            req_reg <= req_next;
            phase_reg <= phase_next;
         end
         hrdata_reg <= hrdata_next;
         cal_d_reg <= cal_active;
         if (counter_clear_event) begin
            cal_done_reg <= 1'b0;
         end else if (cal_d_reg && !cal_active) begin
            cal_done_reg <= 1'b1;
         end
      end
   end
   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule : ccr_readout
`default_nettype wire

//--- ccr_cfg.svh
// register offsets, reset values and field positions of the charge counter readout
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
// printed offsets are register indices; byte address is four times the index
`define CCR_IDX_B2_HIGH 8'h17
`define CCR_IDX_B2_LOW 8'h18
`define CCR_IDX_LIN_HIGH 8'h19
`define CCR_IDX_LIN_LOW 8'h1a
`define CCR_IDX_STATUS 8'h1b
`define CCR_RST_BYTE 8'h00
`define CCR_RST_COUNT 16'h0000
`define CCR_STAT_CAL_BIT 0
`define CCR_STAT_HOLD_B2_BIT 1
`define CCR_STAT_HOLD_LIN_BIT 2
`define CCR_HTRANS_NONSEQ 2'b10
`define CCR_HTRANS_SEQ 2'b11
`endif

//--- ccr_pkg.sv
// types shared by the charge counter readout
`default_nettype none
package ccr_pkg;
   typedef struct packed {
      logic [7:0] index;
      logic valid;
      logic write;
   } ccr_req_t;
   typedef struct packed {
      logic pulse;
      logic clear;
      logic hold;
   } ccr_cnt_ctl_t;
   typedef enum logic [2:0] {
      CCR_IDLE = 3'b001,
      CCR_READ = 3'b010,
      CCR_WRITE = 3'b100
   } ccr_phase_t;
endpackage : ccr_pkg
`default_nettype wire

//--- ccr_counter.sv
// 16-bit charge counter with update hold and high-byte shadow of the low byte
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"
module ccr_counter #(
   parameter int WIDTH = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire ccr_pkg::ccr_cnt_ctl_t ctl,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic snap_low,
   output logic [WIDTH-1:0] count,
   output logic [7:0] shadow_low
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic [7:0] shadow_reg;
   // a pulse during a hold is dropped, never replayed later
   assign count_next = ctl.clear ? '0 :
                       load ? load_value :
                       (ctl.hold ? count_reg :
                        (ctl.pulse ? count_reg + 1'b1 : count_reg));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= `CCR_RST_COUNT;
         shadow_reg <= `CCR_RST_BYTE;
      end else begin
         count_reg <= count_next;
         if (snap_low) begin
            shadow_reg <= count_reg[7:0];
         end
      end
   end
   assign count = count_reg;
   assign shadow_low = shadow_reg;
endmodule : ccr_counter
`default_nettype wire

//--- ccr_pulse_src.sv
// converter-side pulse source that feeds the charge counters
`timescale 1ns/1ps
`default_nettype none
module ccr_pulse_src (
   input wire logic hclk,
   input wire logic start,
   input wire logic [15:0] num,
   output logic pulse,
   output logic busy
);
   logic [16:0] left_reg = 17'h0;
   assign busy = left_reg != 17'h0;
   // one-cycle pulses with a gap, as a prescaler output would give
   assign pulse = busy & left_reg[0];
   always @(posedge hclk) begin
      if (start) left_reg <= {num, 1'b0};
      else if (busy) left_reg <= left_reg - 17'h1;
   end
endmodule : ccr_pulse_src
`default_nettype wire

//--- ccr_readout_assertions.sv
// port-level checks on the charge counter readout
`timescale 1ns/1ps
`default_nettype none
module ccr_readout_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic buck2_pulse,
   input wire logic linear_pulse,
   input wire logic cal_active,
   input wire logic counter_clear_event
);
   wire rd = hsel & hready & htrans[1] & !hwrite;
   // a pulse in the gap would legally move the count
   wire quiet = !buck2_pulse & !linear_pulse & !cal_active;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence clr_rd(logic [31:0] a);
      counter_clear_event ##1 quiet ##1 (rd && haddr == a);
   endsequence
   chk_ready_const: assert property (hreadyout)
      else $error("ready dropped");
   chk_okay_resp: assert property (!hresp)
      else $error("error response");
   chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("upper data bits set");
   chk_rdata_hold: assert property (!rd |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (rd && (haddr < 32'h5c || haddr > 32'h6c ||
      haddr[1:0] != 2'b00) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_reset_zero: assert property (@(posedge hclk) disable iff (1'b0)
      !hresetn |-> hrdata == 32'h0)
      else $error("read data not zero in reset");
   chk_clr_buck2: assert property (clr_rd(32'h5c) |=> hrdata == 32'h0)
      else $error("sleep count not cleared");
   chk_clr_lin: assert property (clr_rd(32'h64) |=> hrdata == 32'h0)
      else $error("linear count not cleared");
endmodule : ccr_readout_assertions
bind ccr_readout ccr_readout_assertions u_chk (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .buck2_pulse(buck2_pulse),
   .linear_pulse(linear_pulse),
   .cal_active(cal_active),
   .counter_clear_event(counter_clear_event)
);
`default_nettype wire

//--- tb_top.sv
// bus-level test of the charge counter readout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b1, hwrite = 1'b0, hp = 1'b0, start = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'b00, sel = 2'd0;
   logic [2:0] hsize = 3'b010;
   logic [15:0] num = 16'h0;
   logic sleep_mode_active = 1'b0, standalone_linear_regulator = 1'b0;
   logic cal_active = 1'b0, counter_clear_event = 1'b0, hreadyout, hresp, pulse, busy;
   int err_count = 0, tests_run = 0, cyc = 0;
   wire hready = hreadyout;
   wire buck2_pulse = (sel == 2'd0 & pulse) | hp;
   wire linear_pulse = sel == 2'd1 & pulse;
   wire cal_tick_10mhz = sel == 2'd2 & pulse;
   ccr_readout dut (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .buck2_pulse(buck2_pulse),
      .sleep_mode_active(sleep_mode_active),
      .linear_pulse(linear_pulse),
      .standalone_linear_regulator(standalone_linear_regulator),
      .cal_active(cal_active),
      .cal_tick_10mhz(cal_tick_10mhz),
      .counter_clear_event(counter_clear_event)
   );
   ccr_pulse_src u_src (.hclk(hclk), .start(start), .num(num), .pulse(pulse), .busy(busy));
   initial begin
      forever #5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask : chk
   // p drives a buck2 pulse through the whole access, which must be lost
   task xfer(input logic [31:0] a, input logic w, input logic p, input logic [7:0] e);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hp <= p;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h000000, ~e};
      do @(posedge hclk); while (hready !== 1'b1);
      hp <= 1'b0;
      if (!w) chk(hrdata, {24'h0, e});
   endtask : xfer
   task src(input logic [1:0] s, input logic [15:0] n);
      @(posedge hclk);
      sel <= s;
      num <= n;
      start <= 1'b1;
      @(posedge hclk);
      start <= 1'b0;
      do @(posedge hclk); while (busy);
   endtask : src
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      // a real falling edge, so the asynchronous reset fires at time zero
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 5; i++) xfer(32'h5c + 32'(4 * i), 0, 0, 8'h00);
      src(0, 3);
      sleep_mode_active <= 1'b1;
      src(0, 300);
      xfer(32'h5c, 0, 0, 8'h01);
      src(0, 3);
      xfer(32'h60, 0, 0, 8'h2c);
      xfer(32'h5c, 0, 1, 8'h01);
      xfer(32'h60, 0, 0, 8'h2f);
      src(0, 1);
      xfer(32'h5c, 1, 0, 8'h00);
      xfer(32'h5c, 0, 0, 8'h01);
      xfer(32'h60, 0, 0, 8'h30);
      xfer(32'h70, 0, 0, 8'h00);
      src(1, 4);
      standalone_linear_regulator <= 1'b1;
      src(1, 5);
      xfer(32'h64, 0, 0, 8'h00);
      xfer(32'h68, 0, 0, 8'h05);
      cal_active <= 1'b1;
      xfer(32'h6c, 0, 0, 8'h01);
      src(2, 20);
      cal_active <= 1'b0;
      src(1, 2);
      xfer(32'h64, 0, 0, 8'h00);
      xfer(32'h68, 0, 0, 8'h14);
      for (int i = 0; i < 2; i++) begin
         counter_clear_event <= 1'b1;
         @(posedge hclk);
         counter_clear_event <= 1'b0;
         xfer(32'h64 - 32'(8 * i), 0, 0, 8'h00);
         xfer(32'h68 - 32'(8 * i), 0, 0, 8'h00);
      end
      conclude();
   end
endmodule : tb_top
`default_nettype wire
